// >>> logic/preset_table.sv
// preset value table and reception start delay per protocol
`include "rf_preset_consts.svh"
module preset_table #(
   parameter logic [15:0] RX_DLY_106 = 16'h0040,
   parameter logic [15:0] RX_DLY_212 = 16'h0020,
   parameter logic [15:0] RX_DLY_424 = 16'h0010,
   parameter logic [15:0] RX_DLY_848 = 16'h0008
) (
   // selection
   input wire logic [3:0] code,
   // table answer
   output rf_preset_pkg::cfg_vec_t values,
   output logic [15:0] rx_delay
);
   import rf_preset_pkg::*;

   always_comb begin
      values = {6{`CFG_RST}};
      rx_delay = RX_DLY_106;
      case (code)
         p_a106: values = `PRE_A106;
         p_a212: begin
            values = `PRE_A212;
            rx_delay = RX_DLY_212;
         end
         p_a424: begin
            values = `PRE_A424;
            rx_delay = RX_DLY_424;
         end
         p_a848: begin
            values = `PRE_A848;
            rx_delay = RX_DLY_848;
         end
         p_b106: values = `PRE_B106;
         p_b212: begin
            values = `PRE_B212;
            rx_delay = RX_DLY_212;
         end
         p_b424: begin
            values = `PRE_B424;
            rx_delay = RX_DLY_424;
         end
         p_b848: begin
            values = `PRE_B848;
            rx_delay = RX_DLY_848;
         end
         p_f212: begin
            values = `PRE_F212;
            rx_delay = RX_DLY_212;
         end
         p_f424: begin
            values = `PRE_F424;
            rx_delay = RX_DLY_424;
         end
         p_i106: values = `PRE_I106;
         p_i212: begin
            values = `PRE_I212;
            rx_delay = RX_DLY_212;
         end
         p_i424: begin
            values = `PRE_I424;
            rx_delay = RX_DLY_424;
         end
         default: begin
            values = {6{`CFG_RST}};
            rx_delay = `RX_DLY_RST;
         end
      endcase
   end
endmodule

// >>> logic/rf_preset_consts.svh
// Function
// - type A reader 106 kbit/s preset is clocking 0x74, modulation 0x2350, undershoot 0x17, overshoot 0x0, drive 0xdbcf43, antenna 0x10.
// - type A reader 212 kbit/s preset is clocking 0x82, modulation 0x2350, undershoot 0x17, overshoot 0x0, drive 0xdbcf043, antenna 0x10.
// - type A reader 424 kbit/s preset is clocking 0x82, modulation 0x650, undershoot 0x5, overshoot 0x0, drive 0xdbcf43, antenna 0x10.
// - type A reader 848 kbit/s preset is clocking 0x82, modulation 0x150, undershoot 0x1, overshoot 0x0, drive 0xf9ef45, antenna 0x10.
// - type B reader 106 kbit/s preset is clocking 0x8e, zero modulation and shaping, drive 0x3a4756, antenna 0x10.
// - type B reader 212 kbit/s preset is clocking 0x8e, zero modulation and shaping, drive 0x39c746, antenna 0x10.
// - type B reader 424 kbit/s preset is clocking 0x78e, zero modulation and undershoot, overshoot 0x1fe0013, drive 0x71cf54, antenna 0x10.
// - type B reader 848 kbit/s preset is clocking 0x78e, zero modulation and undershoot, overshoot 0x7e000d, drive 0x69af32, antenna 0x10.
// - type F reader 212 kbit/s preset is clocking 0x8e, zero modulation and shaping, drive 0x39e744, antenna 0x10.
// - type F reader 424 kbit/s preset is clocking 0x8e, zero modulation and shaping, drive 0x39ef33, antenna 0x10.
// - active initiator 106 kbit/s preset is clocking 0x8782, modulation 0x2350, undershoot 0x17, overshoot 0x0, drive 0xdbcf43, antenna 0x10.
// - active initiator 212 kbit/s preset is clocking 0x808e, zero modulation and shaping, drive 0x39e744, antenna 0x10.
// - active initiator 424 kbit/s preset is clocking 0x808e, zero modulation and shaping, drive 0x39ef33, antenna 0x10.
// - the reception start timer delay is set by the block itself with each preset, never by software.
`ifndef RF_PRESET_CONSTS_SVH
`define RF_PRESET_CONSTS_SVH

`define OFS_CMD 8'h00
`define OFS_STAT 8'h04
`define OFS_RXDLY 8'h08
`define OFS_CFG0 8'h10
`define CFG_SPAN 8'h18
`define CFG_LAST 3'h5
`define PRESET_COUNT 4'hd
`define CMD_CODE_LSB 0
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_ERR_BIT 2
`define STAT_PRESET_LSB 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CFG_RST 32'h0
`define RX_DLY_RST 16'h0

// order in each preset: antenna, drive, overshoot, undershoot, modulation, clocking
`define PRE_A106 {32'h10, 32'hdbcf43, 32'h0, 32'h17, 32'h2350, 32'h74}
`define PRE_A212 {32'h10, 32'hdbcf043, 32'h0, 32'h17, 32'h2350, 32'h82}
`define PRE_A424 {32'h10, 32'hdbcf43, 32'h0, 32'h5, 32'h650, 32'h82}
`define PRE_A848 {32'h10, 32'hf9ef45, 32'h0, 32'h1, 32'h150, 32'h82}
`define PRE_B106 {32'h10, 32'h3a4756, 32'h0, 32'h0, 32'h0, 32'h8e}
`define PRE_B212 {32'h10, 32'h39c746, 32'h0, 32'h0, 32'h0, 32'h8e}
`define PRE_B424 {32'h10, 32'h71cf54, 32'h1fe0013, 32'h0, 32'h0, 32'h78e}
`define PRE_B848 {32'h10, 32'h69af32, 32'h7e000d, 32'h0, 32'h0, 32'h78e}
`define PRE_F212 {32'h10, 32'h39e744, 32'h0, 32'h0, 32'h0, 32'h8e}
`define PRE_F424 {32'h10, 32'h39ef33, 32'h0, 32'h0, 32'h0, 32'h8e}
`define PRE_I106 {32'h10, 32'hdbcf43, 32'h0, 32'h17, 32'h2350, 32'h8782}
`define PRE_I212 {32'h10, 32'h39e744, 32'h0, 32'h0, 32'h0, 32'h808e}
`define PRE_I424 {32'h10, 32'h39ef33, 32'h0, 32'h0, 32'h0, 32'h808e}

`endif

// >>> logic/rf_preset_pkg.sv
// types shared by the transmitter preset loader
package rf_preset_pkg;
   typedef logic [7:0] addr_t;
   typedef logic [5:0][31:0] cfg_vec_t;

   typedef enum logic [3:0] {
      p_a106, p_a212, p_a424, p_a848,
      p_b106, p_b212, p_b424, p_b848,
      p_f212, p_f424,
      p_i106, p_i212, p_i424
   } preset_e;

   typedef enum logic {st_idle, st_load} fsm_e;

   typedef struct packed {
      logic [31:0] antenna_control;
      logic [31:0] transmit_drive_control;
      logic [31:0] transmit_overshoot_shaping;
      logic [31:0] transmit_undershoot_shaping;
      logic [31:0] transmit_data_modulation;
      logic [31:0] transmit_clocking;
   } tx_cfg_s;

   typedef struct packed {
      fsm_e fsm;
      logic [2:0] idx;
      logic [3:0] preset;
      cfg_vec_t cfg;
      logic [15:0] rx_dly;
      logic done;
      logic err;
      logic awready;
      logic aw_held;
      addr_t awaddr;
      logic wready;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } state_s;
endpackage

// >>> logic/rf_tx_preset_loader.sv
// transmitter preset loader with an axi4-lite register slave
`include "rf_preset_consts.svh"
module rf_tx_preset_loader #(
   parameter logic [15:0] RX_DLY_106 = 16'h0040,
   parameter logic [15:0] RX_DLY_212 = 16'h0020,
   parameter logic [15:0] RX_DLY_424 = 16'h0010,
   parameter logic [15:0] RX_DLY_848 = 16'h0008
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address
   input wire logic awvalid,
   output logic awready,
   input wire rf_preset_pkg::addr_t awaddr,
   input wire logic [2:0] awprot,
   // write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // read address
   input wire logic arvalid,
   output logic arready,
   input wire rf_preset_pkg::addr_t araddr,
   input wire logic [2:0] arprot,
   // read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // transmitter configuration
   output rf_preset_pkg::tx_cfg_s tx_cfg,
   output logic [15:0] rx_start_delay,
   output logic load_busy
);
   import rf_preset_pkg::*;

   localparam state_s ST_RST = '{
      fsm: st_idle,
      cfg: {6{`CFG_RST}},
      rx_dly: `RX_DLY_RST,
      awready: 1'b1,
      wready: 1'b1,
      arready: 1'b1,
      bresp: `RESP_OKAY,
      rresp: `RESP_OKAY,
      default: '0
   };

   state_s st_q;
   state_s st_d;
   cfg_vec_t tbl_values;
   logic [15:0] tbl_rx;

   function automatic addr_t word_addr(input addr_t a);
      return {a[7:2], 2'h0};
   endfunction

   function automatic logic is_cfg(input addr_t a);
      return (word_addr(a) >= `OFS_CFG0) && (word_addr(a) < (`OFS_CFG0 + `CFG_SPAN));
   endfunction

   function automatic logic [2:0] cfg_idx(input addr_t a);
      addr_t rel;
      rel = word_addr(a) - `OFS_CFG0;
      return rel[4:2];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] status_word(input state_s s);
      logic [31:0] r;
      r = '0;
      r[`STAT_BUSY_BIT] = (s.fsm == st_load);
      r[`STAT_DONE_BIT] = s.done;
      r[`STAT_ERR_BIT] = s.err;
      r[`STAT_PRESET_LSB +: 4] = s.preset;
      return r;
   endfunction

   // the table always looks at the latched preset, so it is stable during a load
   preset_table #(
      .RX_DLY_106(RX_DLY_106),
      .RX_DLY_212(RX_DLY_212),
      .RX_DLY_424(RX_DLY_424),
      .RX_DLY_848(RX_DLY_848)
   ) u_table (
      .code(st_q.preset),
      .values(tbl_values),
      .rx_delay(tbl_rx)
   );

   always_comb begin
      st_d = st_q;
      // address and data are taken independently, in either order
      if (awvalid && st_q.awready) begin
         st_d.awready = 1'b0;
         st_d.aw_held = 1'b1;
         st_d.awaddr = word_addr(awaddr);
      end
      if (wvalid && st_q.wready) begin
         st_d.wready = 1'b0;
         st_d.w_held = 1'b1;
         st_d.wdata = wdata;
         st_d.wstrb = wstrb;
      end
      if (st_q.bvalid && bready) begin
         st_d.bvalid = 1'b0;
         st_d.awready = 1'b1;
         st_d.wready = 1'b1;
      end
      // both halves held: bvalid is low here, since ready only returns after b
      if (st_q.aw_held && st_q.w_held) begin
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = `RESP_OKAY;
         if (st_q.awaddr == `OFS_CMD) begin
            if (st_q.fsm == st_load) begin
               st_d.bresp = `RESP_SLVERR;
            end else if (st_q.wdata[`CMD_CODE_LSB +: 4] < `PRESET_COUNT) begin
               st_d.preset = st_q.wdata[`CMD_CODE_LSB +: 4];
               st_d.fsm = st_load;
               st_d.idx = 3'h0;
               st_d.done = 1'b0;
               st_d.err = 1'b0;
            end else begin
               st_d.err = 1'b1;
               st_d.bresp = `RESP_SLVERR;
            end
         end else if (st_q.awaddr == `OFS_STAT) begin
            if (st_q.wdata[`STAT_DONE_BIT] && st_q.wstrb[0]) begin
               st_d.done = 1'b0;
            end
            if (st_q.wdata[`STAT_ERR_BIT] && st_q.wstrb[0]) begin
               st_d.err = 1'b0;
            end
         end else if (st_q.awaddr == `OFS_RXDLY) begin
            st_d.bresp = `RESP_SLVERR;
         end else if (is_cfg(st_q.awaddr)) begin
            // the loader owns the registers while a load runs
            if (st_q.fsm == st_load) begin
               st_d.bresp = `RESP_SLVERR;
            end else begin
               st_d.cfg[cfg_idx(st_q.awaddr)] =
                  merge(st_q.cfg[cfg_idx(st_q.awaddr)], st_q.wdata, st_q.wstrb);
            end
         end else begin
            st_d.bresp = `RESP_SLVERR;
         end
      end
      // placed after the write decode so completion wins over a clear of done
      case (st_q.fsm)
         st_idle: begin
            st_d.idx = st_d.idx;
         end
         st_load: begin
            st_d.cfg[st_q.idx] = tbl_values[st_q.idx];
            st_d.idx = st_q.idx + 3'h1;
            if (st_q.idx == `CFG_LAST) begin
               st_d.fsm = st_idle;
               st_d.done = 1'b1;
               st_d.rx_dly = tbl_rx;
            end
         end
         default: begin
            st_d.fsm = st_idle;
         end
      endcase
      // read channel
      if (st_q.rvalid && rready) begin
         st_d.rvalid = 1'b0;
         st_d.arready = 1'b1;
      end
      if (arvalid && st_q.arready) begin
         st_d.arready = 1'b0;
         st_d.rvalid = 1'b1;
         st_d.rresp = `RESP_OKAY;
         st_d.rdata = '0;
         if (word_addr(araddr) == `OFS_CMD) begin
            st_d.rdata[`CMD_CODE_LSB +: 4] = st_q.preset;
         end else if (word_addr(araddr) == `OFS_STAT) begin
            st_d.rdata = status_word(st_q);
         end else if (word_addr(araddr) == `OFS_RXDLY) begin
            st_d.rdata[15:0] = st_q.rx_dly;
         end else if (is_cfg(araddr)) begin
            st_d.rdata = st_q.cfg[cfg_idx(araddr)];
         end else begin
            st_d.rresp = `RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign awready = st_q.awready;
   assign wready = st_q.wready;
   assign bvalid = st_q.bvalid;
   assign bresp = st_q.bresp;
   assign arready = st_q.arready;
   assign rvalid = st_q.rvalid;
   assign rdata = st_q.rdata;
   assign rresp = st_q.rresp;
   assign tx_cfg = tx_cfg_s'(st_q.cfg);
   assign rx_start_delay = st_q.rx_dly;
   // one-bit state: the busy flag comes straight off the state flop
   assign load_busy = logic'(st_q.fsm);

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence load_end(logic [3:0] p);
      st_q.fsm == st_load && st_q.idx == `CFG_LAST && st_q.preset == p;
   endsequence

   sequence load_start;
      st_q.fsm == st_idle ##1 st_q.fsm == st_load;
   endsequence

   sequence load_run;
      !st_q.done ##1 (st_q.fsm == st_load && !st_q.done) [*5]
         ##1 (st_q.fsm == st_idle && st_q.done);
   endsequence

   sequence write_exec;
      st_q.aw_held && st_q.w_held;
   endsequence

   property cfg_after(logic [3:0] p, cfg_vec_t v);
      load_end(p) |=> st_q.cfg == v && st_q.done;
   endproperty

   a_preset_a106: assert property (cfg_after(p_a106, `PRE_A106))
      else $error("type a 106 preset wrong");
   a_preset_a212: assert property (cfg_after(p_a212, `PRE_A212))
      else $error("type a 212 preset wrong");
   a_preset_a424: assert property (cfg_after(p_a424, `PRE_A424))
      else $error("type a 424 preset wrong");
   a_preset_a848: assert property (cfg_after(p_a848, `PRE_A848))
      else $error("type a 848 preset wrong");
   a_preset_b106: assert property (cfg_after(p_b106, `PRE_B106))
      else $error("type b 106 preset wrong");
   a_preset_b212: assert property (cfg_after(p_b212, `PRE_B212))
      else $error("type b 212 preset wrong");
   a_preset_b424: assert property (cfg_after(p_b424, `PRE_B424))
      else $error("type b 424 preset wrong");
   a_preset_b848: assert property (cfg_after(p_b848, `PRE_B848))
      else $error("type b 848 preset wrong");
   a_preset_f212: assert property (cfg_after(p_f212, `PRE_F212))
      else $error("type f 212 preset wrong");
   a_preset_f424: assert property (cfg_after(p_f424, `PRE_F424))
      else $error("type f 424 preset wrong");
   a_preset_i106: assert property (cfg_after(p_i106, `PRE_I106))
      else $error("initiator 106 preset wrong");
   a_preset_i212: assert property (cfg_after(p_i212, `PRE_I212))
      else $error("initiator 212 preset wrong");
   a_preset_i424: assert property (cfg_after(p_i424, `PRE_I424))
      else $error("initiator 424 preset wrong");
   a_rx_delay_set: assert property ($rose(st_q.done) |-> st_q.rx_dly == $past(tbl_rx))
      else $error("reception delay not taken from preset");
   a_rx_delay_hold: assert property (
      st_q.fsm == st_idle ##1 st_q.fsm == st_idle |-> $stable(st_q.rx_dly))
      else $error("reception delay changed outside a load");
   a_load_six_cycles: assert property (load_start |-> load_run)
      else $error("load did not take six cycles before done");
   a_load_first_idx: assert property (load_start |-> st_q.idx == 3'h0)
      else $error("load did not start at the first register");
   // between loads only an executed write may touch the registers
   a_cfg_kept_idle: assert property (
      st_q.fsm == st_idle && !(st_q.aw_held && st_q.w_held) |=> $stable(st_q.cfg))
      else $error("configuration changed with no load and no write");

   // a refused write answers with an error; a bad preset code written while idle also sets the error flag
   a_busy_refused: assert property (
      write_exec ##0 st_q.fsm == st_load |=> st_q.bresp == `RESP_SLVERR)
      else $error("write during a load not refused");
   a_delay_locked: assert property (
      write_exec ##0 st_q.awaddr == `OFS_RXDLY |=> st_q.bresp == `RESP_SLVERR)
      else $error("reception delay write not refused");
   a_bad_code: assert property (
      write_exec ##0 (st_q.awaddr == `OFS_CMD && st_q.fsm == st_idle
         && st_q.wdata[`CMD_CODE_LSB +: 4] >= `PRESET_COUNT)
      |=> st_q.err && st_q.fsm == st_idle)
      else $error("invalid preset code not refused");
   a_cmd_latched: assert property (
      write_exec ##0 (st_q.awaddr == `OFS_CMD && st_q.fsm == st_idle
         && st_q.wdata[`CMD_CODE_LSB +: 4] < `PRESET_COUNT)
      |=> st_q.fsm == st_load && st_q.preset == st_q.wdata[`CMD_CODE_LSB +: 4])
      else $error("valid preset code did not start a load");

   // each answer stands until the host takes it; one transfer per channel
   a_write_answer: assert property (write_exec |=> st_q.bvalid)
      else $error("write response missing");
   a_bvalid_hold: assert property (
      st_q.bvalid && !bready |=> st_q.bvalid && $stable(st_q.bresp))
      else $error("write response dropped before taken");
   a_write_closed: assert property (st_q.bvalid |-> !st_q.awready && !st_q.wready)
      else $error("write channels open while a response waits");
   a_ready_back: assert property (
      st_q.bvalid && bready |=> st_q.awready && st_q.wready && !st_q.bvalid)
      else $error("write channels not reopened");
   a_aw_taken: assert property (
      awvalid && st_q.awready |=> !st_q.awready && st_q.aw_held)
      else $error("write address not taken");
   a_w_taken: assert property (
      wvalid && st_q.wready |=> !st_q.wready && st_q.w_held)
      else $error("write data not taken");
   a_read_answer: assert property (arvalid && st_q.arready |=> st_q.rvalid)
      else $error("read response missing");
   a_read_closed: assert property (st_q.rvalid |-> !st_q.arready)
      else $error("read address open while data waits");
   a_rvalid_hold: assert property (
      st_q.rvalid && !rready |=> st_q.rvalid && $stable(st_q.rdata))
      else $error("read data dropped before taken");
   a_rready_back: assert property (
      st_q.rvalid && rready |=> st_q.arready && !st_q.rvalid)
      else $error("read channel not reopened");
endmodule

// >>> verification/axil_host.sv
// axi4-lite host model issuing register cycles to the preset loader
module axil_host
   import rf_preset_pkg::*;
(
   // clock
   input wire logic aclk,
   // write address and data
   output logic awvalid,
   input wire logic awready,
   output addr_t awaddr,
   output logic [2:0] awprot,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   // write response
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   // read channels
   output logic arvalid,
   input wire logic arready,
   output addr_t araddr,
   output logic [2:0] arprot,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      awvalid = 1'b0;
      awaddr = 8'h00;
      awprot = 3'h0;
      wvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hf;
      bready = 1'b0;
      arvalid = 1'b0;
      araddr = 8'h00;
      arprot = 3'h0;
      rready = 1'b0;
   end

   // address and data offered together, each dropped once its own channel takes it
   task automatic wr(input addr_t a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      logic pend;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      pend = 1'b1;
      r = 2'h3;
      for (int n = 0; n < 64 && pend; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            pend = 1'b0;
         end
      end
      if (pend) rf_tx_preset_loader_tb_top.hang();
   endtask

   task automatic rd(input addr_t a, output logic [31:0] d, output logic [1:0] r);
      logic pend;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      pend = 1'b1;
      d = 32'h0;
      r = 2'h3;
      for (int n = 0; n < 64 && pend; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            pend = 1'b0;
         end
      end
      if (pend) rf_tx_preset_loader_tb_top.hang();
   endtask
endmodule

// >>> verification/rf_tx_preset_loader_tb_top.sv
// self-checking bench for the transmitter preset loader
`include "rf_preset_consts.svh"
module rf_tx_preset_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rf_preset_pkg::*;

   // distinct delays so a wrong bit rate pick shows up
   localparam logic [15:0] D106 = 16'h0011;
   localparam logic [15:0] D212 = 16'h0022;
   localparam logic [15:0] D424 = 16'h0044;
   localparam logic [15:0] D848 = 16'h0088;

   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, load_busy;
   addr_t awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   tx_cfg_s tx_cfg;
   logic [15:0] rx_start_delay;
   int fail_count, checks;

   axil_host host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp));

   rf_tx_preset_loader #(.RX_DLY_106(D106), .RX_DLY_212(D212), .RX_DLY_424(D424),
      .RX_DLY_848(D848)) dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .tx_cfg(tx_cfg), .rx_start_delay(rx_start_delay), .load_busy(load_busy));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // order: antenna, drive, overshoot, undershoot, modulation, clocking
   function automatic tx_cfg_s exp_cfg(input int c);
      case (c)
         0: return {32'h10, 32'hdbcf43, 32'h0, 32'h17, 32'h2350, 32'h74};
         1: return {32'h10, 32'hdbcf043, 32'h0, 32'h17, 32'h2350, 32'h82};
         2: return {32'h10, 32'hdbcf43, 32'h0, 32'h5, 32'h650, 32'h82};
         3: return {32'h10, 32'hf9ef45, 32'h0, 32'h1, 32'h150, 32'h82};
         4: return {32'h10, 32'h3a4756, 32'h0, 32'h0, 32'h0, 32'h8e};
         5: return {32'h10, 32'h39c746, 32'h0, 32'h0, 32'h0, 32'h8e};
         6: return {32'h10, 32'h71cf54, 32'h1fe0013, 32'h0, 32'h0, 32'h78e};
         7: return {32'h10, 32'h69af32, 32'h7e000d, 32'h0, 32'h0, 32'h78e};
         8: return {32'h10, 32'h39e744, 32'h0, 32'h0, 32'h0, 32'h8e};
         9: return {32'h10, 32'h39ef33, 32'h0, 32'h0, 32'h0, 32'h8e};
         10: return {32'h10, 32'hdbcf43, 32'h0, 32'h17, 32'h2350, 32'h8782};
         11: return {32'h10, 32'h39e744, 32'h0, 32'h0, 32'h0, 32'h808e};
         12: return {32'h10, 32'h39ef33, 32'h0, 32'h0, 32'h0, 32'h808e};
         default: return '0;
      endcase
   endfunction

   function automatic logic [15:0] exp_dly(input int c);
      case (c)
         0, 4, 10: return D106;
         1, 5, 8, 11: return D212;
         2, 6, 9, 12: return D424;
         default: return D848;
      endcase
   endfunction

   task automatic check(input string what, input logic [191:0] exp, input logic [191:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_chk(input addr_t a, input logic [31:0] d, input logic [1:0] er,
                         input logic [3:0] s = 4'hf);
      logic [1:0] r;
      host.wr(a, d, s, r);
      check("bresp", er, r);
   endtask

   task automatic rd_chk(input addr_t a, input logic [31:0] m, input logic [31:0] e,
                         input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      host.rd(a, d, r);
      check("rresp", er, r);
      check("rdata", e, d & m);
   endtask

   task automatic hang();
      fail_count++;
      $display("wrong value handshake expected answer seen none");
      finish_test();
   endtask

   task automatic wait_idle();
      for (int n = 0; n < 40 && load_busy !== 1'b0; n++) @(posedge aclk);
      if (load_busy !== 1'b0) hang();
      #1;
   endtask

   task automatic test_reset();
      #1;
      check("tx_cfg", '0, tx_cfg);
      check("rx_start_delay", 16'h0, rx_start_delay);
      check("load_busy", 1'b0, load_busy);
      rd_chk(`OFS_CFG0, 32'hffffffff, 32'h0, `RESP_OKAY);
   endtask

   // every code loads its full set, its own delay, then reports done
   task automatic test_presets();
      tx_cfg_s e;
      for (int c = 0; c < 13; c++) begin
         e = exp_cfg(c);
         wr_chk(`OFS_CMD, c, `RESP_OKAY);
         #1;
         check("load_busy", 1'b1, load_busy);
         wait_idle();
         check("tx_cfg", exp_cfg(c), tx_cfg);
         check("rx_start_delay", exp_dly(c), rx_start_delay);
         rd_chk(`OFS_STAT, 32'hf7, {c[3:0], 4'h2}, `RESP_OKAY);
         rd_chk(8'h20, 32'hffffffff, e.transmit_drive_control, `RESP_OKAY);
      end
   endtask

   // requests landing in mid-load are refused and leave the load intact
   task automatic test_busy();
      wr_chk(`OFS_CMD, 32'h4, `RESP_OKAY);
      wr_chk(`OFS_CMD, 32'h7, `RESP_SLVERR);
      wait_idle();
      check("tx_cfg", exp_cfg(4), tx_cfg);
      wr_chk(`OFS_CMD, 32'h6, `RESP_OKAY);
      wr_chk(8'h14, 32'h1234, `RESP_SLVERR);
      wait_idle();
      check("tx_cfg", exp_cfg(6), tx_cfg);
      rd_chk(`OFS_RXDLY, 32'hffff, exp_dly(6), `RESP_OKAY);
   endtask

   task automatic test_refusals();
      for (int c = 13; c < 16; c++) begin
         wr_chk(`OFS_CMD, c, `RESP_SLVERR);
         #1;
         check("load_busy", 1'b0, load_busy);
      end
      check("tx_cfg", exp_cfg(6), tx_cfg);
      rd_chk(`OFS_STAT, 32'hf4, 32'h64, `RESP_OKAY);
      // with no byte enabled the error flag must survive a clear
      wr_chk(`OFS_STAT, 32'h6, `RESP_OKAY, 4'h0);
      rd_chk(`OFS_STAT, 32'h4, 32'h4, `RESP_OKAY);
      wr_chk(`OFS_STAT, 32'h6, `RESP_OKAY);
      rd_chk(`OFS_STAT, 32'h6, 32'h0, `RESP_OKAY);
      // host may never set the reception delay
      wr_chk(`OFS_RXDLY, 32'h5555, `RESP_SLVERR);
      #1;
      check("rx_start_delay", exp_dly(6), rx_start_delay);
      wr_chk(8'h40, 32'h1, `RESP_SLVERR);
      rd_chk(8'h40, 32'hffffffff, 32'h0, `RESP_SLVERR);
   endtask

   // a host value is overwritten by the next load
   task automatic test_overwrite();
      wr_chk(8'h24, 32'h55, `RESP_OKAY);
      #1;
      check("antenna_control", 32'h55, tx_cfg.antenna_control);
      wr_chk(8'h24, 32'haaaa12bb, `RESP_OKAY, 4'h2);
      #1;
      check("antenna_control", 32'h1255, tx_cfg.antenna_control);
      wr_chk(`OFS_CMD, 32'h3, `RESP_OKAY);
      wait_idle();
      check("tx_cfg", exp_cfg(3), tx_cfg);
   endtask

   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      fail_count = 0;
      checks = 0;
      aresetn = 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      test_reset();
      test_presets();
      test_busy();
      test_refusals();
      test_overwrite();
      finish_test();
   end
endmodule
